//--- hw/udx_pkg.sv
// Shared constants, types and helpers for the divide / exclusive-OR execution block
package udx_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_OPWORD = 8'h08;
	localparam logic [7:0] OFF_EXTWORD = 8'h0c;
	localparam logic [7:0] OFF_SRC = 8'h10;
	localparam logic [7:0] OFF_MEMDST = 8'h14;
	localparam logic [7:0] OFF_CCR = 8'h18;
	localparam logic [7:0] OFF_RESULT = 8'h1c;
	localparam logic [7:0] OFF_DREG0 = 8'h20;
	localparam logic [7:0] OFF_DREG7 = 8'h3c;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_GO = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ILLEGAL = 2;
	localparam int ST_ZERODIV = 3;
	localparam int ST_STORE = 4;
	localparam int ST_OVF = 5;
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_X = 4;
	localparam logic [4:0] CCR_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// ----------------------------------------
	// Opcode fields and addressing modes
	// ----------------------------------------
	localparam logic [3:0] OPC_DIVW = 4'h8;
	localparam logic [3:0] OPC_XOR = 4'hb;
	localparam logic [9:0] OPC_DIVL = 10'h131;
	localparam logic [2:0] OPM_DIVW = 3'h7;
	localparam logic [2:0] OPM_XOR_B = 3'h4;
	localparam logic [2:0] OPM_XOR_W = 3'h5;
	localparam logic [2:0] OPM_XOR_L = 3'h6;
	localparam logic [2:0] MODE_DREG = 3'h0;
	localparam logic [2:0] MODE_AREG = 3'h1;
	localparam logic [2:0] MODE_EXT = 3'h7;
	localparam logic [2:0] EXT_ABS_W = 3'h0;
	localparam logic [2:0] EXT_ABS_L = 3'h1;
	localparam logic [2:0] EXT_PC_DISP = 3'h2;
	localparam logic [2:0] EXT_PC_IDX = 3'h3;
	localparam logic [2:0] EXT_IMM = 3'h4;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {OP_NONE = 2'b00, OP_DIVW = 2'b01, OP_DIVL = 2'b10, OP_XOR = 2'b11} op_kind_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_EXEC = 2'b01, S_DIV = 2'b10} exec_state_t;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Lane mask of an operand size
	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		size_mask = (sz == SZ_BYTE) ? 32'h0000_00ff : (sz == SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction
	// Sign bit of a value at an operand size
	function automatic logic size_msb(input logic [31:0] v, input logic [1:0] sz);
		size_msb = (sz == SZ_BYTE) ? v[7] : (sz == SZ_WORD) ? v[15] : v[31];
	endfunction
endpackage

//--- hw/udiv_if.sv
// Request and answer bundle between the executor and the sequential divider
`timescale 1ns/100ps
interface udiv_if;
	logic start;
	logic word;
	logic [63:0] dividend;
	logic [31:0] divisor;
	logic done;
	logic ovf;
	logic [31:0] quotient;
	logic [31:0] remainder;
	modport requester(output start, word, dividend, divisor, input done, ovf, quotient, remainder);
	modport divider(input start, word, dividend, divisor, output done, ovf, quotient, remainder);
endinterface

//--- hw/udx_decode.sv
// Opcode and addressing-mode decoder for the divide / exclusive-OR executor
`timescale 1ns/100ps
module udx_decode import udx_pkg::*; (
	// Instruction words
	input wire logic [15:0] i_opword,
	input wire logic [15:0] i_extword,
	// Decoded operation
	output op_kind_t o_kind,
	output logic o_legal,
	output logic [1:0] o_size,
	output logic o_long64,
	output logic [2:0] o_dst_reg,
	output logic [2:0] o_rem_reg
);
	logic [2:0] mode;
	logic [2:0] reg_f;
	logic [2:0] opm;
	logic data_mode;
	logic alter_mode;
	logic ext_ok;

	// Operand fields
	assign mode = i_opword[5:3];
	assign reg_f = i_opword[2:0];
	assign opm = i_opword[8:6];

	// Source may be any data mode, never an address register
	always_comb begin
		data_mode = (mode != MODE_AREG);
		if (mode == MODE_EXT) begin
			data_mode = (reg_f == EXT_ABS_W) || (reg_f == EXT_ABS_L) || (reg_f == EXT_IMM) ||
				(reg_f == EXT_PC_DISP) || (reg_f == EXT_PC_IDX);
		end
	end

	// Destination must be data alterable: no An, immediate or PC-relative
	assign alter_mode = (mode != MODE_AREG) &&
		((mode != MODE_EXT) || (reg_f == EXT_ABS_W) || (reg_f == EXT_ABS_L));

	// Extension word: unsigned, all bits other than the register fields and size bit 10 zero
	assign ext_ok = !i_extword[15] && !i_extword[11] && (i_extword[9:3] == 7'h00);

	// Opcode classification
	always_comb begin
		o_kind = OP_NONE;
		o_size = SZ_LONG;
		if ((i_opword[15:12] == OPC_DIVW) && (opm == OPM_DIVW)) begin
			o_kind = OP_DIVW;
			o_size = SZ_WORD;
		end else if (i_opword[15:6] == OPC_DIVL) begin
			o_kind = OP_DIVL;
		end else if ((i_opword[15:12] == OPC_XOR) && ((opm == OPM_XOR_B) || (opm == OPM_XOR_W) ||
				(opm == OPM_XOR_L))) begin
			o_kind = OP_XOR;
			o_size = opm[1:0];
		end
	end

	// Any other encoding, a memory-to-register form among them, is refused
	always_comb begin
		unique case (o_kind)
			OP_DIVW: o_legal = data_mode;
			OP_DIVL: o_legal = data_mode && ext_ok;
			OP_XOR: o_legal = alter_mode;
			OP_NONE: o_legal = 1'b0;
		endcase
	end

	// Register fields
	assign o_dst_reg = (o_kind == OP_DIVL) ? i_extword[14:12] : i_opword[11:9];
	assign o_rem_reg = i_extword[2:0];
	assign o_long64 = i_extword[10];
endmodule

//--- hw/udiv_seq.sv
// Restoring unsigned divider, one quotient bit per cycle, with early overflow exit
`timescale 1ns/100ps
module udiv_seq import udx_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Request and answer
	udiv_if.divider p
);
	logic [31:0] rem;
	logic [31:0] quo;
	logic [5:0] count;
	logic run;
	logic ovf_chk;
	logic [32:0] shifted;
	logic [32:0] diff;

	// Word form stops at the signed 16-bit bound, so quotient bit 15 must stay clear; long form at 32 bits
	assign ovf_chk = p.word ? (p.dividend[31:15] >= {1'b0, p.divisor[15:0]}) :
		(p.dividend[63:32] >= p.divisor);
	assign shifted = {rem, quo[31]};
	assign diff = shifted - {1'b0, p.divisor};
	assign p.quotient = quo;
	assign p.remainder = rem;

	// Iteration; the divisor is held steady by the requester while running
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rem <= WORD_RESET;
			quo <= WORD_RESET;
			count <= 6'h00;
			run <= 1'b0;
			p.done <= 1'b0;
			p.ovf <= 1'b0;
		end else begin
			p.done <= 1'b0;
			if (p.start) begin
				p.ovf <= ovf_chk;
				if (ovf_chk) begin
					p.done <= 1'b1;
				end else begin
					run <= 1'b1;
					count <= DIV_STEPS;
					rem <= p.dividend[63:32];
					quo <= p.dividend[31:0];
				end
			end else if (run) begin
				if (!diff[32]) begin
					rem <= diff[31:0];
					quo <= {quo[30:0], 1'b1};
				end else begin
					rem <= shifted[31:0];
					quo <= {quo[30:0], 1'b0};
				end
				count <= count - 6'h01;
				if (count == 6'h01) begin
					run <= 1'b0;
					p.done <= 1'b1;
				end
			end
		end
	end
endmodule

//--- hw/unsigned_divide_and_xor_exec.sv
// Execution block for unsigned divide and register exclusive-OR, reached over APB
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - Divide N from quotient sign, C cleared, X kept
// - Divide Z set when quotient is zero
// - Divide V set on overflow, else cleared
// - Word divide uses register field as destination
// - Word divide overflows past signed 16-bit bound
// - Long divide overflows when quotient exceeds 32 bits
// - Divide source: data modes only, no An
// - Mode 111 subfield decodes absolute, immediate, PC
// - Long divide reads and writes quotient register
// - Size bit picks 32- or 64-bit dividend
// - Remainder to its register unless same as quotient
// - 64-bit dividend high half from remainder register
// - Exclusive-OR data register into destination, any size
// - Exclusive-OR N, Z from result; V, C cleared
// - Opmode 100/101/110 selects byte, word, long
// - Exclusive-OR destination must be data alterable
// - Memory-to-register exclusive-OR form is refused
// - Word divide: quotient low half, remainder high
// - Zero divisor abandons divide with a trap
// - Overflow sets V, leaves operands untouched
module unsigned_divide_and_xor_exec import udx_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Execution events
	output logic o_busy,
	output logic o_illegal_trap,
	output logic o_zero_divide_trap,
	output logic o_store_pending
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	exec_state_t state;
	exec_state_t next_state;
	logic [31:0] dreg [8];
	logic [15:0] opword;
	logic [15:0] extword;
	logic [31:0] src_operand;
	logic [31:0] mem_dest;
	logic [31:0] result;
	logic [4:0] ccr;
	logic done;
	logic illegal;
	logic zero_div;
	logic ovf_seen;
	logic [31:0] next_prdata;
	logic addr_ok;
	logic apb_access;
	logic wr_en;
	logic go;

	// Decoder outputs
	op_kind_t kind;
	logic legal;
	logic [1:0] size;
	logic long64;
	logic [2:0] dst_reg;
	logic [2:0] rem_reg;

	// Execute-cycle values
	logic [31:0] src_val;
	logic [31:0] divisor;
	logic [63:0] dividend;
	logic [31:0] xor_dst;
	logic [31:0] xor_res;
	logic [31:0] mask;
	logic dst_is_dreg;

	udiv_if div_bus();

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	udx_decode u_decode (
		.i_opword(opword),
		.i_extword(extword),
		.o_kind(kind),
		.o_legal(legal),
		.o_size(size),
		.o_long64(long64),
		.o_dst_reg(dst_reg),
		.o_rem_reg(rem_reg)
	);

	udiv_seq u_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.p(div_bus.divider)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state: pready is a flop so the answer is never combinational
	assign apb_access = i_psel && i_penable && !o_pready;
	assign wr_en = apb_access && i_pwrite;
	assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= OFF_DREG7);
	assign go = wr_en && (i_paddr == OFF_CTRL) && i_pwdata[CTRL_GO] && (state == S_IDLE);

	// Read mux, unmapped addresses read zero
	always_comb begin
		next_prdata = WORD_RESET;
		if (i_paddr >= OFF_DREG0 && addr_ok) begin
			next_prdata = dreg[i_paddr[4:2]];
		end else begin
			unique case (i_paddr)
				OFF_STATUS: next_prdata = {26'h0, ovf_seen, o_store_pending, zero_div, illegal, done, o_busy};
				OFF_OPWORD: next_prdata = {16'h0, opword};
				OFF_EXTWORD: next_prdata = {16'h0, extword};
				OFF_SRC: next_prdata = src_operand;
				OFF_MEMDST: next_prdata = mem_dest;
				OFF_CCR: next_prdata = {27'h0, ccr};
				OFF_RESULT: next_prdata = result;
				default: next_prdata = WORD_RESET;
			endcase
		end
	end

	// Answer phase flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pready <= 1'b0;
			o_prdata <= WORD_RESET;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= apb_access;
			o_pslverr <= apb_access && !addr_ok;
			if (apb_access && !i_pwrite) begin
				o_prdata <= next_prdata;
			end
		end
	end

	// Software-loaded instruction and operand words, frozen while busy
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			opword <= 16'h0000;
			extword <= 16'h0000;
			src_operand <= WORD_RESET;
			mem_dest <= WORD_RESET;
		end else if (wr_en && state == S_IDLE) begin
			unique case (i_paddr)
				OFF_OPWORD: opword <= i_pwdata[15:0];
				OFF_EXTWORD: extword <= i_pwdata[15:0];
				OFF_SRC: src_operand <= i_pwdata;
				OFF_MEMDST: mem_dest <= i_pwdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Operand preparation
	// ----------------------------------------
	assign dst_is_dreg = (opword[5:3] == MODE_DREG);
	assign src_val = dst_is_dreg ? dreg[opword[2:0]] : src_operand;
	assign mask = size_mask(size);

	// Dividend and divisor for both divide forms
	always_comb begin
		if (kind == OP_DIVW) begin
			divisor = {16'h0, src_val[15:0]};
			dividend = {32'h0, dreg[dst_reg]};
		end else begin
			divisor = src_val;
			dividend = {long64 ? dreg[rem_reg] : WORD_RESET, dreg[dst_reg]};
		end
	end

	// Exclusive-OR keeps the untouched lanes of the destination
	assign xor_dst = dst_is_dreg ? dreg[opword[2:0]] : mem_dest;
	assign xor_res = (xor_dst & ~mask) | ((xor_dst ^ dreg[opword[11:9]]) & mask);

	// Divisor held in the interface for the whole run
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			div_bus.start <= 1'b0;
			div_bus.word <= 1'b0;
			div_bus.dividend <= 64'h0;
			div_bus.divisor <= WORD_RESET;
		end else begin
			div_bus.start <= 1'b0;
			if (state == S_EXEC && legal && kind != OP_XOR && divisor != WORD_RESET) begin
				div_bus.start <= 1'b1;
				div_bus.word <= (kind == OP_DIVW);
				div_bus.dividend <= dividend;
				div_bus.divisor <= divisor;
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: if (go) next_state = S_EXEC;
			S_EXEC: if (legal && kind != OP_XOR && divisor != WORD_RESET) next_state = S_DIV;
				else next_state = S_IDLE;
			S_DIV: if (div_bus.done) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= S_IDLE;
			o_busy <= 1'b0;
		end else begin
			state <= next_state;
			o_busy <= (next_state != S_IDLE);
		end
	end

	// Trap pulses and sticky completion status, cleared by the next start
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_illegal_trap <= 1'b0;
			o_zero_divide_trap <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			zero_div <= 1'b0;
			ovf_seen <= 1'b0;
		end else begin
			o_illegal_trap <= 1'b0;
			o_zero_divide_trap <= 1'b0;
			if (go) begin
				done <= 1'b0;
				illegal <= 1'b0;
				zero_div <= 1'b0;
				ovf_seen <= 1'b0;
			end
			if (state == S_EXEC && !legal) begin
				o_illegal_trap <= 1'b1;
				illegal <= 1'b1;
				done <= 1'b1;
			end else if (state == S_EXEC && kind != OP_XOR && divisor == WORD_RESET) begin
				o_zero_divide_trap <= 1'b1;
				zero_div <= 1'b1;
				done <= 1'b1;
			end else if (state == S_EXEC) begin
				done <= 1'b1;
			end else if (state == S_DIV && div_bus.done) begin
				ovf_seen <= div_bus.ovf;
				done <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Result placement
	// ----------------------------------------
	// Data registers: software writes only while idle, results only while busy
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 8; i++) begin
				dreg[i] <= WORD_RESET;
			end
		end else if (wr_en && state == S_IDLE && i_paddr >= OFF_DREG0 && addr_ok) begin
			dreg[i_paddr[4:2]] <= i_pwdata;
		end else if (state == S_EXEC && legal && kind == OP_XOR && dst_is_dreg) begin
			dreg[opword[2:0]] <= xor_res;
		end else if (state == S_DIV && div_bus.done && !div_bus.ovf) begin
			if (kind == OP_DIVW) begin
				dreg[dst_reg] <= {div_bus.remainder[15:0], div_bus.quotient[15:0]};
			end else begin
				if (rem_reg != dst_reg) begin
					dreg[rem_reg] <= div_bus.remainder;
				end
				dreg[dst_reg] <= div_bus.quotient;
			end
		end
	end

	// Memory destination value waits here for the bus unit to store it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			result <= WORD_RESET;
			o_store_pending <= 1'b0;
		end else if (go) begin
			o_store_pending <= 1'b0;
		end else if (state == S_EXEC && legal && kind == OP_XOR && !dst_is_dreg) begin
			result <= xor_res;
			o_store_pending <= 1'b1;
		end
	end

	// Condition codes; X is never written by either operation
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ccr <= CCR_RESET;
		end else if (wr_en && state == S_IDLE && i_paddr == OFF_CCR) begin
			ccr <= i_pwdata[4:0];
		end else if (state == S_EXEC && legal && kind == OP_XOR) begin
			ccr[CCR_N] <= size_msb(xor_res, size);
			ccr[CCR_Z] <= ((xor_res & mask) == WORD_RESET);
			ccr[CCR_V] <= 1'b0;
			ccr[CCR_C] <= 1'b0;
		end else if (state == S_DIV && div_bus.done) begin
			ccr[CCR_C] <= 1'b0;
			ccr[CCR_V] <= div_bus.ovf;
			if (!div_bus.ovf) begin
				ccr[CCR_N] <= (kind == OP_DIVW) ? div_bus.quotient[15] : div_bus.quotient[31];
				ccr[CCR_Z] <= (kind == OP_DIVW) ? (div_bus.quotient[15:0] == 16'h0000) :
					(div_bus.quotient == WORD_RESET);
			end
		end
	end
endmodule

//--- dv/udx_exec_sva.sv
// Port-level checker for the divide / exclusive-OR block: bus timing and execution events
`timescale 1ns/100ps
module udx_exec_sva (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Execution events
	input wire logic o_busy,
	input wire logic o_illegal_trap,
	input wire logic o_zero_divide_trap,
	input wire logic o_store_pending
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic acc;
	logic bad;
	logic go;
	logic [7:0] busy_cnt;
	// First access cycle, address outside the map, and a go request
	assign acc = i_psel && i_penable && !o_pready;
	assign bad = (i_paddr > 8'h3c) || (i_paddr[1:0] != 2'h0);
	assign go = acc && i_pwrite && (i_paddr == 8'h00) && i_pwdata[0] && !o_busy;
	// Busy length; a full divide is the longest job, so a stuck busy shows here
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !o_busy) begin
			busy_cnt <= 8'h00;
		end else begin
			busy_cnt <= busy_cnt + 8'h01;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_ready_one_wait: assert property (acc |=> o_pready) else $error("pready not one cycle after access");
	a_ready_single: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
	a_err_with_ready: assert property (o_pslverr |-> o_pready && i_psel && i_penable) else $error("stray pslverr");
	a_unmapped_err: assert property (acc && bad |=> o_pslverr) else $error("unmapped access without error");
	a_mapped_no_err: assert property (acc && !bad |=> !o_pslverr) else $error("mapped access with error");
	a_go_sets_busy: assert property (go |-> ##[1:2] o_busy) else $error("go did not start the job");
	a_go_clears_store: assert property (go |-> ##[1:2] !o_store_pending) else $error("store flag not cleared by go");
	a_busy_bounded: assert property (busy_cnt <= 8'd40) else $error("busy too long");
	a_illegal_pulse: assert property (o_illegal_trap |=> !o_illegal_trap) else $error("illegal trap held");
	a_zdiv_pulse: assert property (o_zero_divide_trap |=> !o_zero_divide_trap) else $error("zdiv trap held");
	a_traps_apart: assert property (!(o_illegal_trap && o_zero_divide_trap)) else $error("both traps");
	a_trap_ends_busy: assert property ((o_illegal_trap || o_zero_divide_trap) |-> !o_busy)
		else $error("trap while busy");
endmodule

bind unsigned_divide_and_xor_exec udx_exec_sva u_sva (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_pready, .o_pslverr, .o_busy, .o_illegal_trap, .o_zero_divide_trap, .o_store_pending);

//--- dv/tb_top.sv
// Self-checking testbench for the divide / exclusive-OR block, driven over APB
`timescale 1ns/100ps
module tb_top import udx_pkg::*; ;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic o_pready, o_pslverr, o_busy, o_illegal_trap, o_zero_divide_trap, o_store_pending;
	logic [31:0] o_prdata;
	int n_fail = 0;
	int samples_checked = 0;
	unsigned_divide_and_xor_exec DUT (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_pready, .o_prdata, .o_pslverr, .o_busy, .o_illegal_trap, .o_zero_divide_trap, .o_store_pending);
	// 100 MHz clock
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// ----------------------------------------
	// Reporting and bus tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic void chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("Error at %0t: %s", $time, msg);
		end
	endfunction
	// One APB transfer; an idle edge first keeps back-to-back calls from double driving
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		// Pready as sampled at each rising edge; data taken and request released at that same edge
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (k >= 20) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk(e === 1'b0, "write refused");
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r === exp && e === 1'b0, msg);
	endtask
	function automatic logic [7:0] da(input int n);
		return OFF_DREG0 + 8'(n * 4);
	endfunction
	// Load an instruction, start it and poll until idle
	task automatic run(input logic [15:0] op, input logic [15:0] ext, output logic [31:0] st);
		int k;
		logic e;
		wr(OFF_OPWORD, {16'h0, op});
		wr(OFF_EXTWORD, {16'h0, ext});
		wr(OFF_CTRL, 32'h1);
		k = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0, st, e);
			k++;
		end while (st[ST_BUSY] !== 1'b0 && k < 60);
		if (k >= 60) begin
			n_fail++;
			give_verdict();
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_map();
		logic [31:0] r;
		logic e;
		rd_chk(OFF_STATUS, 32'h0, "status reset");
		rd_chk(OFF_CCR, 32'h0, "flags reset");
		rd_chk(da(7), 32'h0, "register reset");
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk(e === 1'b1 && r === 32'h0, "unmapped read");
		apb(1'b1, 8'h06, 32'h1, r, e);
		chk(e === 1'b1, "misaligned write");
		wr(OFF_CCR, 32'h1f);
		rd_chk(OFF_CCR, 32'h1f, "flags write");
	endtask
	task automatic t_word_div();
		logic [31:0] st;
		logic [31:0] r;
		logic e;
		wr(da(0), 32'd100);
		wr(da(1), 32'd7);
		wr(OFF_CCR, 32'h11);
		run(16'h81c1, 16'h0, st);
		rd_chk(da(0), {16'd2, 16'd14}, "word divide result");
		rd_chk(OFF_CCR, 32'h10, "word divide flags");
		wr(da(0), 32'd3);
		run(16'h81c1, 16'h0, st);
		rd_chk(da(0), 32'h0003_0000, "zero quotient");
		rd_chk(OFF_CCR, 32'h14, "zero quotient flags");
		wr(da(0), 32'h0003_7fff);
		run(16'h81c1, 16'h0, st);
		rd_chk(da(0), {16'd6, 16'h7fff}, "largest word quotient");
		rd_chk(OFF_CCR, 32'h10, "largest word quotient flags");
		wr(da(0), 32'h0003_8000);
		run(16'h81c1, 16'h0, st);
		chk(st[ST_OVF] === 1'b1, "signed word bound overflow");
		rd_chk(da(0), 32'h0003_8000, "bound overflow keeps operand");
		wr(da(0), 32'h0010_0000);
		run(16'h81c1, 16'h0, st);
		chk(st[ST_OVF] === 1'b1, "word overflow status");
		apb(1'b0, OFF_CCR, 32'h0, r, e);
		chk(r[CCR_V] === 1'b1 && r[CCR_C] === 1'b0 && r[CCR_X] === 1'b1, "overflow flags");
		rd_chk(da(0), 32'h0010_0000, "overflow keeps operand");
		wr(da(1), 32'd0);
		run(16'h81c1, 16'h0, st);
		chk(st[ST_ZERODIV] === 1'b1, "zero divisor trap");
		rd_chk(da(0), 32'h0010_0000, "zero divisor keeps operand");
	endtask
	task automatic t_long_div();
		logic [31:0] st;
		logic [31:0] r;
		logic e;
		wr(da(2), 32'd1);
		wr(da(3), 32'd0);
		wr(da(4), 32'd2);
		wr(OFF_CCR, 32'h10);
		run(16'h4c44, 16'h3402, st);
		rd_chk(da(3), 32'h8000_0000, "wide quotient");
		rd_chk(da(2), 32'h0, "wide remainder");
		rd_chk(OFF_CCR, 32'h18, "wide flags");
		wr(da(2), 32'h55);
		wr(da(3), 32'd17);
		wr(da(4), 32'd5);
		run(16'h4c44, 16'h3002, st);
		rd_chk(da(3), 32'd3, "narrow quotient");
		rd_chk(da(2), 32'd2, "narrow remainder");
		wr(da(3), 32'd17);
		run(16'h4c44, 16'h3003, st);
		rd_chk(da(3), 32'd3, "shared register holds quotient");
		wr(da(2), 32'd5);
		wr(da(3), 32'd0);
		wr(da(4), 32'd2);
		run(16'h4c44, 16'h3402, st);
		apb(1'b0, OFF_CCR, 32'h0, r, e);
		chk(r[CCR_V] === 1'b1, "long overflow");
		rd_chk(da(2), 32'd5, "long overflow keeps operands");
	endtask
	task automatic t_xor();
		logic [31:0] st;
		logic [31:0] exp [3] = '{32'hffff_fff0, 32'hffff_f0f0, 32'hf0f0_f0f0};
		for (int i = 0; i < 3; i++) begin
			wr(da(0), 32'hffff_ffff);
			wr(da(1), 32'h0f0f_0f0f);
			wr(OFF_CCR, 32'h1f);
			run(16'hb300 + 16'(i * 'h40), 16'h0, st);
			rd_chk(da(0), exp[i], "xor result");
			rd_chk(OFF_CCR, 32'h18, "xor flags");
		end
		wr(da(0), 32'h1234_560f);
		run(16'hb300, 16'h0, st);
		rd_chk(da(0), 32'h1234_5600, "byte xor keeps upper");
		rd_chk(OFF_CCR, 32'h14, "byte xor zero");
		wr(OFF_MEMDST, 32'h5555_aaaa);
		run(16'hb390, 16'h0, st);
		rd_chk(OFF_RESULT, 32'h5a5a_a5a5, "memory xor result");
		chk(o_store_pending === 1'b1, "store pending");
		run(16'hb300, 16'h0, st);
		chk(o_store_pending === 1'b0, "store pending cleared");
	endtask
	task automatic t_modes();
		logic [31:0] st;
		logic [15:0] ok_op [10] = '{16'h81d0, 16'h81d8, 16'h81e0, 16'h81e8, 16'h81f0, 16'h81f8, 16'h81f9,
			16'h81fa, 16'h81fb, 16'h81fc};
		logic [15:0] bad_op [10] = '{16'h81c9, 16'h81fd, 16'h81fe, 16'hb308, 16'hb33c, 16'hb33a, 16'hb33b,
			16'hb000, 16'h4c44, 16'h4c44};
		logic [15:0] bad_ext [10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3802,
			16'h3412};
		wr(OFF_SRC, 32'd7);
		foreach (ok_op[i]) begin
			wr(da(0), 32'd100);
			run(ok_op[i], 16'h0, st);
			rd_chk(da(0), {16'd2, 16'd14}, "divide source mode");
		end
		foreach (bad_op[i]) begin
			run(bad_op[i], bad_ext[i], st);
			chk(st[ST_ILLEGAL] === 1'b1, "illegal encoding");
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_map();
		t_word_div();
		t_long_div();
		t_xor();
		t_modes();
		give_verdict();
	end
endmodule
